/* ppo_pkg.sv */
// ppo_pkg.sv - register map and constants of the pulse pattern unit
package ppo_pkg;
  // ------------------------------------------------------------------
  // register word offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [4:0] OFS_NDE_HIGH  = 5'h00;
  localparam logic [4:0] OFS_NDE_LOW   = 5'h04;
  localparam logic [4:0] OFS_POD_HIGH  = 5'h08;
  localparam logic [4:0] OFS_POD_LOW   = 5'h0C;
  localparam logic [4:0] OFS_NEXT_HIGH = 5'h10;
  localparam logic [4:0] OFS_NEXT_LOW  = 5'h14;
  localparam logic [4:0] OFS_TRIG_SEL  = 5'h18;

  // ------------------------------------------------------------------
  // reset values and field layout
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_TRIG_SEL = 8'h00;
  localparam int         GROUPS       = 4;
  localparam int         GROUP_BITS   = 4;
  localparam int         TRIG_SRCS    = 4;
  localparam int         TRIG_SEL_W   = 2;
  localparam int         SYNC_STAGES  = 3;

  // ------------------------------------------------------------------
  // bus slave states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PPO_IDLE = 2'b01,
    PPO_ACK  = 2'b10
  } ppo_bus_state_t;
endpackage

/* ppo_trig_sync.sv */
// ppo_trig_sync.sv - trigger synchroniser with rising edge detect
`timescale 1ns/1ns
`default_nettype none
module ppo_trig_sync
  import ppo_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // asynchronous compare event in, one-cycle pulse out
  input  wire logic async_in,
  output logic      edge_pulse
);
  // ------------------------------------------------------------------
  // three stage synchroniser; only stages two and three are compared
  // ------------------------------------------------------------------
  logic [SYNC_STAGES-1:0] sync;
  logic                   level;
  logic [SYNC_STAGES-1:0] next_sync;
  logic                   next_level;
  logic                   next_edge;

  // a change counts only once stage two and three agree
  always_comb begin
    next_sync  = {sync[SYNC_STAGES-2:0], async_in};
    next_level = level;
    if (sync[1] == sync[2]) begin
      next_level = sync[2];
    end
    next_edge  = next_level & ~level;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync       <= '0;
      level      <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      sync       <= next_sync;
      level      <= next_level;
      edge_pulse <= next_edge;
    end
  end
endmodule
`default_nettype wire

/* ppo_top.sv */
// ppo_top.sv - pulse pattern output unit with wishbone register slave
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module ppo_top
  import ppo_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // wishbone classic slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [4:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      wb_err_o,
  // compare events from the timer unit, asynchronous
  input  wire logic [TRIG_SRCS-1:0] timer_compare,
  // pattern pins 15 to 0
  output logic      [15:0]          pattern_pin
);
  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  function automatic logic is_mapped(input logic [4:0] a);
    is_mapped = (a == OFS_NDE_HIGH)  || (a == OFS_NDE_LOW)   ||
                (a == OFS_POD_HIGH)  || (a == OFS_POD_LOW)   ||
                (a == OFS_NEXT_HIGH) || (a == OFS_NEXT_LOW)  ||
                (a == OFS_TRIG_SEL);
  endfunction

  // byte lane zero carries every register
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs,
                               input logic we, input logic [3:0] sel);
    hit = we && sel[0] && (a == ofs);
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  ppo_bus_state_t state;
  ppo_bus_state_t next_state;
  logic [15:0]    transfer_enable;
  logic [15:0]    pulse_output_data;
  logic [15:0]    next_value;
  logic [7:0]     trig_sel;
  logic [31:0]    next_dat_o;
  logic           next_err;
  logic [15:0]    next_transfer_enable;
  logic [15:0]    next_pulse_output_data;
  logic [15:0]    next_next_value;
  logic [7:0]     next_trig_sel;
  logic [TRIG_SRCS-1:0] trig_pulse;
  logic [GROUPS-1:0]    group_fire;
  logic                 wr_take;

  // ------------------------------------------------------------------
  // compare event synchronisers
  // ------------------------------------------------------------------
  // timing is borrowed from the timer's compare events, no own base
  genvar gi;
  generate
    for (gi = 0; gi < TRIG_SRCS; gi++) begin : g_sync
      ppo_trig_sync u_sync (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .async_in   (timer_compare[gi]),
        .edge_pulse (trig_pulse[gi])
      );
    end
  endgenerate

  // per group trigger choice, two select bits per group
  generate
    for (gi = 0; gi < GROUPS; gi++) begin : g_fire
      assign group_fire[gi] =
        trig_pulse[trig_sel[gi*TRIG_SEL_W +: TRIG_SEL_W]];
    end
  endgenerate

  // ------------------------------------------------------------------
  // wishbone slave: one wait state, ack for one cycle
  // ------------------------------------------------------------------
  assign wr_take = (state == PPO_IDLE) && wb_cyc_i && wb_stb_i;

  always_comb begin
    next_state = state;
    next_dat_o = wb_dat_o;
    next_err   = 1'b0;
    case (state)
      PPO_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          next_state = PPO_ACK;
          next_err   = ~is_mapped(wb_adr_i);
          next_dat_o = 32'h0000_0000;
          case (wb_adr_i)
            OFS_NDE_HIGH:  next_dat_o[7:0] = transfer_enable[15:8];
            OFS_NDE_LOW:   next_dat_o[7:0] = transfer_enable[7:0];
            OFS_POD_HIGH:  next_dat_o[7:0] = pulse_output_data[15:8];
            OFS_POD_LOW:   next_dat_o[7:0] = pulse_output_data[7:0];
            OFS_NEXT_HIGH: next_dat_o[7:0] = next_value[15:8];
            OFS_NEXT_LOW:  next_dat_o[7:0] = next_value[7:0];
            OFS_TRIG_SEL:  next_dat_o[7:0] = trig_sel;
            default:       next_dat_o      = 32'h0000_0000;
          endcase
        end
      end
      PPO_ACK: begin
        next_state = PPO_IDLE;
      end
      default: begin
        next_state = PPO_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // register writes and pattern transfer
  // ------------------------------------------------------------------
  // writes land at the request edge; ack rises at that same edge
  always_comb begin
    next_transfer_enable   = transfer_enable;
    next_next_value        = next_value;
    next_trig_sel          = trig_sel;
    next_pulse_output_data = pulse_output_data;
    if (wr_take && hit(wb_adr_i, OFS_NDE_HIGH, wb_we_i, wb_sel_i)) begin
      next_transfer_enable[15:8] = wb_dat_i[7:0];
    end
    if (wr_take && hit(wb_adr_i, OFS_NDE_LOW, wb_we_i, wb_sel_i)) begin
      next_transfer_enable[7:0] = wb_dat_i[7:0];
    end
    if (wr_take && hit(wb_adr_i, OFS_NEXT_HIGH, wb_we_i, wb_sel_i)) begin
      next_next_value[15:8] = wb_dat_i[7:0];
    end
    if (wr_take && hit(wb_adr_i, OFS_NEXT_LOW, wb_we_i, wb_sel_i)) begin
      next_next_value[7:0] = wb_dat_i[7:0];
    end
    if (wr_take && hit(wb_adr_i, OFS_TRIG_SEL, wb_we_i, wb_sel_i)) begin
      next_trig_sel = wb_dat_i[7:0];
    end
    // software may only touch bits whose transfer is off
    if (wr_take && hit(wb_adr_i, OFS_POD_HIGH, wb_we_i, wb_sel_i)) begin
      next_pulse_output_data[15:8] =
        (pulse_output_data[15:8] & transfer_enable[15:8]) |
        (wb_dat_i[7:0] & ~transfer_enable[15:8]);
    end
    if (wr_take && hit(wb_adr_i, OFS_POD_LOW, wb_we_i, wb_sel_i)) begin
      next_pulse_output_data[7:0] =
        (pulse_output_data[7:0] & transfer_enable[7:0]) |
        (wb_dat_i[7:0] & ~transfer_enable[7:0]);
    end
    // trigger copy; enabled bits are never written above, so no clash
    for (int g = 0; g < GROUPS; g++) begin
      for (int b = 0; b < GROUP_BITS; b++) begin
        if (group_fire[g] && transfer_enable[g*GROUP_BITS+b]) begin
          next_pulse_output_data[g*GROUP_BITS+b] =
            next_value[g*GROUP_BITS+b];
        end
      end
    end
    // bits with enable 0 simply keep their value here
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state             <= PPO_IDLE;
      wb_dat_o          <= 32'h0000_0000;
      wb_ack_o          <= 1'b0;
      wb_err_o          <= 1'b0;
      transfer_enable   <= {RST_BYTE, RST_BYTE};
      pulse_output_data <= {RST_BYTE, RST_BYTE};
      next_value        <= {RST_BYTE, RST_BYTE};
      trig_sel          <= RST_TRIG_SEL;
      pattern_pin       <= 16'h0000;
    end else begin
      state             <= next_state;
      wb_dat_o          <= next_dat_o;
      wb_ack_o          <= (next_state == PPO_ACK) && !next_err;
      wb_err_o          <= (next_state == PPO_ACK) && next_err;
      transfer_enable   <= next_transfer_enable;
      pulse_output_data <= next_pulse_output_data;
      next_value        <= next_next_value;
      trig_sel          <= next_trig_sel;
      pattern_pin       <= next_pulse_output_data;
    end
  end
endmodule
`default_nettype wire

/* ppo_timer_model.sv */
// ppo_timer_model.sv - stand-in for the timer unit's compare events
`timescale 1ns/1ns
`default_nettype none
module ppo_timer_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // bench request, one pulse per event
  input  wire logic [3:0] fire_req,
  // compare event levels
  output logic      [3:0] timer_compare
);
  logic [2:0] hold [4];
  // each event stays high four cycles so the 3-stage sync sees one edge
  for (genvar n = 0; n < 4; n++) begin : g_src
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        hold[n] <= 3'h0;
      end else if (fire_req[n]) begin
        hold[n] <= 3'h4;
      end else if (hold[n] != 3'h0) begin
        hold[n] <= hold[n] - 3'h1;
      end
    end
    assign timer_compare[n] = (hold[n] != 3'h0);
  end
endmodule
`default_nettype wire

/* ppo_top_checker.sv */
// ppo_top_checker.sv - port assertions for the pulse pattern unit
`timescale 1ns/1ns
`default_nettype none
module ppo_top_checker
  import ppo_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // bus and pins as seen at the top
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_ack_o,
  input  wire logic                 wb_err_o,
  input  wire logic [31:0]          wb_dat_o,
  input  wire logic [TRIG_SRCS-1:0] timer_compare,
  input  wire logic [15:0]          pattern_pin
);
  logic [3:0] prev_cmp;
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  // cycles since any compare line moved; saturates so it never wraps
  always_comb begin
    next_quiet = (quiet == 4'hF) ? quiet : quiet + 4'h1;
    if (timer_compare != prev_cmp) next_quiet = 4'h0;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_cmp <= 4'h0;
      quiet    <= 4'hF;
    end else begin
      prev_cmp <= timer_compare;
      quiet    <= next_quiet;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ERR_PULSE: assert property (wb_err_o |=> !wb_err_o)
    else $error("err held longer than one cycle");
  AST_ONE_ANSWER: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  AST_ANSWER_NEXT: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o &&
    !wb_err_o) |=> (wb_ack_o ^ wb_err_o)) else $error("no answer in time");
  AST_NO_STRAY: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_HIGH_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_PIN_CAUSE: assert property ($changed(pattern_pin) |->
    (wb_ack_o || quiet < 4'h8)) else $error("pins moved without cause");
  AST_ERR_NOWR: assert property ((wb_err_o && quiet > 4'h8) |->
    $stable(pattern_pin)) else $error("unmapped write moved pins");
endmodule
bind ppo_top ppo_top_checker ppo_top_checker_i (.core_clk(core_clk),
  .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wb_dat_o(wb_dat_o),
  .timer_compare(timer_compare), .pattern_pin(pattern_pin));
`default_nettype wire

/* tb_top.sv */
// tb_top.sv - register and trigger tests of the pulse pattern unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import ppo_pkg::*;
  logic core_clk, rstn, cyc, stb, we, ack, err, last_err;
  logic [4:0] adr;
  logic [31:0] dat, dat_o;
  logic [3:0] frq, cmp;
  logic [15:0] pins;
  logic [7:0] q;
  int mismatches, n_tests;
  int srcs[4] = '{3, 0, 1, 2};
  logic [15:0] exps[4] = '{16'hCCA5, 16'hCCAA, 16'hCCAA, 16'hCCAA};
  ppo_top ppo_top_i (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
    .timer_compare(cmp), .pattern_pin(pins));
  ppo_timer_model ppo_timer_model_i (.core_clk(core_clk), .rstn(rstn),
    .fire_req(frq), .timer_compare(cmp));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // one classic cycle; waits for ack or err under a bounded count
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge core_clk);
    while (!(ack || err) && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20) mismatches++;
    q = dat_o[7:0];
    last_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  // one compare event, then enough cycles for sync and copy to settle
  task automatic fire(input int s);
    frq <= 4'h1 << s;
    @(posedge core_clk);
    frq <= 4'h0;
    repeat (10) @(posedge core_clk);
  endtask
  task automatic finish_test;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #(50 * 3000);
    mismatches++;
    finish_test();
  end
  initial begin
    rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 5'h00; dat = 32'h0; frq = 4'h0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 7; i++) begin
      bus(5'(i * 4), 1'b0, 8'h00);
      `CHK(q, RST_BYTE)
    end
    bus(5'h1C, 1'b1, 8'hFF);
    `CHK(last_err, 1'b1)
    // initial levels go in while every enable is still clear
    bus(OFS_POD_LOW, 1'b1, 8'hA5);
    bus(OFS_POD_HIGH, 1'b1, 8'h3C);
    `CHK(pins, 16'h3CA5)
    bus(OFS_TRIG_SEL, 1'b1, 8'hE4);
    bus(OFS_TRIG_SEL, 1'b0, 8'h00);
    `CHK(q, 8'hE4)
    bus(OFS_NEXT_LOW, 1'b1, 8'h5A);
    bus(OFS_NEXT_HIGH, 1'b1, 8'hC3);
    bus(OFS_NDE_LOW, 1'b1, 8'h0F);
    bus(OFS_NDE_HIGH, 1'b1, 8'hF0);
    // group g follows source g only, and disabled groups hold
    for (int i = 0; i < 4; i++) begin
      fire(srcs[i]);
      `CHK(pins, exps[i])
    end
    bus(OFS_POD_LOW, 1'b1, 8'h00);
    bus(OFS_POD_LOW, 1'b0, 8'h00);
    `CHK(q, 8'h0A)
    bus(OFS_POD_HIGH, 1'b1, 8'h00);
    bus(OFS_POD_HIGH, 1'b0, 8'h00);
    `CHK(q, 8'hC0)
    `CHK(pins, 16'hC00A)
    finish_test();
  end
endmodule
`default_nettype wire
